// ---- rtl/frpc_top.sv ----
// top: flash read path, command engine and page buffer write path
`timescale 1ns/100ps
module frpc_top (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_wait_state_select,
   input wire logic i_sequential_buffer_enable,
   input wire logic i_branch_buffer_enable,
   input wire logic [frpc_pkg::REGIONS-1:0] i_region_lock,
   input wire logic i_status_clear,
   input wire logic i_rd_req,
   input wire logic [frpc_pkg::ADDR_W-1:0] i_rd_addr,
   output logic o_rd_ready,
   output logic o_rd_valid,
   output logic [31:0] o_rd_data,
   input wire logic i_pbw_valid,
   input wire logic [frpc_pkg::ADDR_W-1:0] i_pbw_addr,
   input wire logic [31:0] i_pbw_data,
   output logic o_pbw_ready,
   output logic o_pbuf_wr,
   output logic [frpc_pkg::PBUF_IDX_W-1:0] o_pbuf_idx,
   output logic [31:0] o_pbuf_data,
   input wire logic i_pbuf_ready,
   input wire logic i_cmd_valid,
   input wire logic [frpc_pkg::CMD_W-1:0] i_cmd,
   input wire logic [frpc_pkg::PAGE_W-1:0] i_cmd_page,
   output logic o_command_ready,
   output logic o_fast_read_active,
   output logic o_page_check_result,
   output logic o_lock_error,
   output logic o_arr_rd,
   output logic [frpc_pkg::LOC_W-1:0] o_arr_loc,
   input wire logic [63:0] i_arr_rdata,
   output logic o_arr_prog,
   output logic [frpc_pkg::CMD_W-1:0] o_arr_op,
   output logic [frpc_pkg::PAGE_W-1:0] o_arr_page,
   input wire logic i_arr_prog_done
);
   typedef enum logic [1:0] {CS_IDLE, CS_WAIT_IDLE, CS_READ, CS_PROG} frpc_cmd_e;

   typedef struct packed {
      frpc_cmd_e cs;
      logic cmd_rdy;
      logic fast;
      logic chk_res;
      logic lock_err;
      logic [frpc_pkg::CMD_W-1:0] cmd;
      logic [frpc_pkg::PAGE_W-1:0] page;
      logic [frpc_pkg::CHK_IDX_W-1:0] chk_idx;
      logic chk_acc;
      logic prog;
      logic ready;
      logic valid;
      logic [31:0] rdata;
      logic owed;
      logic owed_have;
      logic owed_hi;
      logic [31:0] owed_word;
      logic [frpc_pkg::LOC_W-1:0] owed_loc;
      logic pend;
      logic cnt;
      logic pend_dem;
      logic [frpc_pkg::LOC_W-1:0] pend_loc;
      logic bvalid;
      logic [frpc_pkg::LOC_W-1:0] bloc;
      logic [63:0] bdata;
      logic bany; // both halves usable, not only the companion
      logic brvalid;
      logic [frpc_pkg::LOC_W-1:0] brloc;
      logic [63:0] brdata;
      logic arr_rd;
      logic [frpc_pkg::LOC_W-1:0] arr_loc;
      logic pbw_v;
      logic [frpc_pkg::PBUF_IDX_W-1:0] pbw_idx;
      logic [31:0] pbw_data;
   } frpc_state_s;

   frpc_state_s q, d;
   logic ws1, land, acc, rsv, user_addr, hit, inflight, miss, prefetch, seqpf;
   logic chk_done, chk_and, locked, cmd_start;
   logic [frpc_pkg::LOC_W-1:0] acc_loc, chk_loc;
   logic [63:0] hit_loc_data;
   logic [31:0] hit_word;

   frpc_stream_if #(.WIDTH(frpc_pkg::PBW_W)) pbw_in ();
   frpc_stream_if #(.WIDTH(frpc_pkg::PBW_W)) pbw_out ();

   // page buffer writes queue here until the array side takes them
   frpc_fifo #(.WIDTH(frpc_pkg::PBW_W), .DEPTH(frpc_pkg::FIFO_DEPTH)) u_pbw_fifo (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .s_in(pbw_in.sink),
      .s_out(pbw_out.source)
   );

   assign pbw_in.valid = i_pbw_valid;
   assign pbw_in.data = {i_pbw_addr[frpc_pkg::PBUF_IDX_W+1:2], i_pbw_data};
   assign pbw_out.ready = !q.pbw_v || i_pbuf_ready;

   function automatic frpc_state_s launch(input frpc_state_s s,
                                         input logic [frpc_pkg::LOC_W-1:0] loc,
                                         input logic dem, input logic slow);
      s.arr_rd = 1'b1;
      s.arr_loc = loc;
      s.pend = 1'b1;
      s.cnt = slow;
      s.pend_loc = loc;
      s.pend_dem = dem;
      return s;
   endfunction

   assign ws1 = i_wait_state_select;
   assign land = q.pend && !q.cnt;
   assign acc = q.ready && i_rd_req;
   assign acc_loc = i_rd_addr[frpc_pkg::ADDR_W-1:3];
   assign user_addr = (i_rd_addr >= frpc_pkg::USER_BASE) && (i_rd_addr < frpc_pkg::USER_END);
   // gap above the array and everything past the user page
   assign rsv = (i_rd_addr >= frpc_pkg::ARRAY_BYTES) && !user_addr;
   assign hit = ws1 && ((land && q.pend_loc == acc_loc)
                || (q.bvalid && q.bloc == acc_loc && (q.bany || i_rd_addr[2]))
                || (i_branch_buffer_enable && q.brvalid && q.brloc == acc_loc));
   assign inflight = ws1 && q.pend && !land && q.pend_loc == acc_loc;
   assign miss = acc && !rsv && !hit && !inflight;
   assign prefetch = acc && hit && i_rd_addr[2];
   // speculative next location after a demand fetch, only when the port is quiet
   assign seqpf = ws1 && i_sequential_buffer_enable && land && q.pend_dem && !acc;
   assign hit_loc_data = (land && q.pend_loc == acc_loc) ? i_arr_rdata :
                         (q.bvalid && q.bloc == acc_loc) ? q.bdata : q.brdata;
   assign hit_word = i_rd_addr[2] ? hit_loc_data[63:32] : hit_loc_data[31:0];
   assign chk_and = q.chk_acc & (&i_arr_rdata);
   assign locked = i_region_lock[q.page[frpc_pkg::PAGE_W-1 -: frpc_pkg::REGION_W]];
   assign cmd_start = (q.cs == CS_WAIT_IDLE) && !q.owed && !q.pend;
   assign chk_loc = (q.cmd == frpc_pkg::CMD_USER_CHECK)
                    ? (frpc_pkg::USER_LOC | frpc_pkg::LOC_W'(q.chk_idx))
                    : frpc_pkg::LOC_W'({q.page, q.chk_idx});

   always_comb
   begin
      d = q;
      d.valid = 1'b0;
      d.arr_rd = 1'b0;
      d.prog = 1'b0;
      chk_done = 1'b0;
      if (q.pend && q.cnt)
         d.cnt = 1'b0;
      if (land)
      begin
         d.pend = 1'b0;
         d.bvalid = 1'b1;
         d.bloc = q.pend_loc;
         d.bdata = i_arr_rdata;
         d.bany = !q.pend_dem;
         if (q.pend_dem && ws1 && i_branch_buffer_enable)
         begin
            d.brvalid = 1'b1;
            d.brloc = q.pend_loc;
            d.brdata = i_arr_rdata;
         end
      end
      // answer the owed read as soon as its word is at hand
      if (q.owed && (q.owed_have || (land && q.pend_loc == q.owed_loc)))
      begin
         d.owed = 1'b0;
         d.valid = 1'b1;
         d.rdata = q.owed_have ? q.owed_word
                   : (q.owed_hi ? i_arr_rdata[63:32] : i_arr_rdata[31:0]);
      end
      if (seqpf)
         d = launch(d, q.pend_loc + 1'b1, 1'b0, ws1);
      if (acc)
      begin
         d.owed = 1'b1;
         d.owed_loc = acc_loc;
         d.owed_hi = i_rd_addr[2];
         d.owed_have = rsv || hit;
         d.owed_word = rsv ? frpc_pkg::RESERVED_DATA : hit_word;
         if (miss)
         begin
            d = launch(d, acc_loc, 1'b1, ws1);
            d.bvalid = 1'b0;
         end
         else if (prefetch)
            d = launch(d, acc_loc + 1'b1, 1'b0, ws1);
      end
      if (i_status_clear)
         d.lock_err = 1'b0;
      case (q.cs)
         CS_IDLE:
            if (i_cmd_valid)
            begin
               d.cmd_rdy = 1'b0;
               d.cmd = i_cmd;
               d.page = i_cmd_page;
               d.cs = CS_WAIT_IDLE;
            end
         CS_WAIT_IDLE:
            if (cmd_start)
            begin
               d.cs = CS_IDLE;
               d.cmd_rdy = 1'b1;
               case (q.cmd)
                  frpc_pkg::CMD_FAST_ON: d.fast = 1'b1;
                  frpc_pkg::CMD_FAST_OFF: d.fast = 1'b0;
                  frpc_pkg::CMD_PAGE_CHECK, frpc_pkg::CMD_USER_CHECK:
                  begin
                     d.cs = CS_READ;
                     d.cmd_rdy = 1'b0;
                     d.chk_idx = '0;
                     d.chk_acc = 1'b1;
                  end
                  frpc_pkg::CMD_WRITE_PAGE, frpc_pkg::CMD_ERASE_PAGE:
                     if (locked)
                        d.lock_err = 1'b1;
                     else
                     begin
                        d.prog = 1'b1;
                        d.cs = CS_PROG;
                        d.cmd_rdy = 1'b0;
                     end
                  // user page only through its own commands, never locked
                  frpc_pkg::CMD_WRITE_USER, frpc_pkg::CMD_ERASE_USER:
                  begin
                     d.prog = 1'b1;
                     d.cs = CS_PROG;
                     d.cmd_rdy = 1'b0;
                  end
                  default: d.cmd_rdy = 1'b1;
               endcase
            end
         CS_READ:
         begin
            if (!q.pend)
               d = launch(d, chk_loc, 1'b0, ws1);
            if (land)
            begin
               d.chk_acc = chk_and;
               if (q.chk_idx == frpc_pkg::CHK_LAST)
               begin
                  chk_done = 1'b1;
                  d.chk_res = chk_and;
                  d.cs = CS_IDLE;
                  d.cmd_rdy = 1'b1;
               end
               else
                  d.chk_idx = q.chk_idx + 1'b1;
            end
         end
         CS_PROG:
            if (i_arr_prog_done)
            begin
               d.cs = CS_IDLE;
               d.cmd_rdy = 1'b1;
            end
         default: d.cs = CS_IDLE;
      endcase
      // stall while a command runs, or unless the owed word will be ready at the next edge
      d.ready = (d.cs == CS_IDLE) && (!d.owed || d.owed_have
                || (d.pend && !d.cnt && d.pend_loc == d.owed_loc));
      if (pbw_out.ready)
      begin
         d.pbw_v = pbw_out.valid;
         d.pbw_idx = pbw_out.data[frpc_pkg::PBW_W-1:32];
         d.pbw_data = pbw_out.data[31:0];
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         q <= '0;
         q.cmd_rdy <= 1'b1;
         q.ready <= 1'b1;
      end
      else
         q <= d;
   end

   assign o_rd_ready = q.ready;
   assign o_rd_valid = q.valid;
   assign o_rd_data = q.rdata;
   assign o_pbw_ready = pbw_in.ready;
   assign o_pbuf_wr = q.pbw_v;
   assign o_pbuf_idx = q.pbw_idx;
   assign o_pbuf_data = q.pbw_data;
   assign o_command_ready = q.cmd_rdy;
   assign o_fast_read_active = q.fast;
   assign o_page_check_result = q.chk_res;
   assign o_lock_error = q.lock_err;
   assign o_arr_rd = q.arr_rd;
   assign o_arr_loc = q.arr_loc;
   assign o_arr_prog = q.prog;
   assign o_arr_op = q.cmd;
   assign o_arr_page = q.page;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_reset_n);

   sequence s_one_stall;
      !o_rd_ready ##1 (o_rd_ready && !o_rd_valid) ##1 o_rd_valid;
   endsequence

   sequence s_prefetch_then_word(logic [frpc_pkg::LOC_W-1:0] nxt);
      (o_arr_rd && o_arr_loc == nxt) ##1 o_rd_valid;
   endsequence

   zero_ws_rate_a: assert property (acc && !ws1 && !i_cmd_valid |=> o_rd_ready ##1 o_rd_valid)
      else $error("zero wait state read stalled");
   fetch_pair_a: assert property (land && !miss |=> q.bvalid && q.bloc == $past(q.pend_loc)
      && q.bdata == $past(i_arr_rdata))
      else $error("companion word not kept");
   seq_prefetch_a: assert property (prefetch |=> s_prefetch_then_word($past(acc_loc) + 1'b1))
      else $error("sequential hit did not prefetch next location");
   first_stall_a: assert property (miss && ws1 && !i_cmd_valid |=> s_one_stall)
      else $error("one wait state miss did not stall exactly once");
   no_buffer_zero_a: assert property (acc && !ws1 && !rsv
      |=> o_arr_rd && o_arr_loc == $past(acc_loc))
      else $error("zero wait state read used a buffer");
   reserved_read_a: assert property (acc && rsv |=> !o_arr_rd ##1 (o_rd_valid
      && o_rd_data == frpc_pkg::RESERVED_DATA))
      else $error("reserved read touched the array");
   user_map_a: assert property (acc && !ws1 && user_addr
      |=> o_arr_rd && o_arr_loc[frpc_pkg::LOC_W-1])
      else $error("user page read not mapped to user page");
   cmd_clear_a: assert property (i_cmd_valid && o_command_ready |=> !o_command_ready)
      else $error("command write left ready set");
   fast_on_a: assert property (cmd_start && q.cmd == frpc_pkg::CMD_FAST_ON
      |=> o_fast_read_active && o_command_ready)
      else $error("fast read mode not entered");
   lock_refuse_a: assert property (cmd_start && locked && (q.cmd == frpc_pkg::CMD_WRITE_PAGE
      || q.cmd == frpc_pkg::CMD_ERASE_PAGE) |=> o_lock_error && !o_arr_prog && o_command_ready)
      else $error("locked region was modified");
   check_result_a: assert property (chk_done |=> o_page_check_result == $past(chk_and)
      && o_command_ready)
      else $error("page check result wrong");
   miss_discard_a: assert property (miss |=> !q.bvalid && o_arr_rd && o_arr_loc == $past(acc_loc))
      else $error("non-sequential read kept stale companion");
endmodule // frpc_top

// ---- rtl/frpc_pkg.sv ----
// package: constants for the flash read path controller
package frpc_pkg;
   localparam int ADDR_W = 24;
   localparam int LOC_W = 21;
   localparam int CMD_W = 4;
   localparam int PAGE_W = 10;
   localparam int REGIONS = 16;
   localparam int REGION_W = 4;
   localparam int CHK_IDX_W = 5;
   localparam int PBUF_IDX_W = 6;
   localparam int PBW_W = PBUF_IDX_W + 32;
   localparam int FIFO_DEPTH = 4;
   // array size is a plain default, not a figure of any part
   localparam logic [ADDR_W-1:0] ARRAY_BYTES = 24'h040000;
   localparam logic [ADDR_W-1:0] USER_BASE = 24'h800000;
   localparam logic [ADDR_W-1:0] USER_END = 24'h800100;
   localparam logic [LOC_W-1:0] USER_LOC = 21'h100000;
   localparam logic [CHK_IDX_W-1:0] CHK_LAST = 5'h1f;
   localparam logic [31:0] RESERVED_DATA = 32'h00000000;
   localparam logic [CMD_W-1:0] CMD_NOP = 4'h0;
   localparam logic [CMD_W-1:0] CMD_WRITE_PAGE = 4'h1;
   localparam logic [CMD_W-1:0] CMD_ERASE_PAGE = 4'h2;
   localparam logic [CMD_W-1:0] CMD_WRITE_USER = 4'h3;
   localparam logic [CMD_W-1:0] CMD_ERASE_USER = 4'h4;
   localparam logic [CMD_W-1:0] CMD_FAST_ON = 4'h5;
   localparam logic [CMD_W-1:0] CMD_FAST_OFF = 4'h6;
   localparam logic [CMD_W-1:0] CMD_PAGE_CHECK = 4'h7;
   localparam logic [CMD_W-1:0] CMD_USER_CHECK = 4'h8;
endpackage

// ---- rtl/frpc_stream_if.sv ----
// interface: valid/ready word stream between the controller's modules
`timescale 1ns/100ps
interface frpc_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport sink (input valid, input data, output ready);
   modport source (output valid, output data, input ready);
endinterface

// ---- rtl/frpc_fifo.sv ----
// fifo: small valid/ready buffer with registered full and empty
`timescale 1ns/100ps
module frpc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   frpc_stream_if.sink s_in,
   frpc_stream_if.source s_out
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic full;
      logic empty;
   } frpc_fifo_s;

   frpc_fifo_s q, d;
   logic push, pop;

   assign push = s_in.valid && !q.full;
   assign pop = s_out.ready && !q.empty;
   assign s_in.ready = !q.full;
   assign s_out.valid = !q.empty;
   assign s_out.data = q.mem[q.rp];

   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wp] = s_in.data;
         d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
      end
      if (pop)
         d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
      if (push && !pop)
         d.cnt = q.cnt + 1'b1;
      else if (pop && !push)
         d.cnt = q.cnt - 1'b1;
      d.full = (d.cnt == (AW + 1)'(DEPTH));
      d.empty = (d.cnt == '0);
   end

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         q <= '0;
         q.empty <= 1'b1;
      end
      else
         q <= d;
   end

   fifo_bound_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (q.cnt <= (AW + 1)'(DEPTH)) && (q.full == (q.cnt == (AW + 1)'(DEPTH))))
      else $error("fifo count out of range or full flag wrong");
endmodule // frpc_fifo

// ---- bench/frpc_array_model.sv ----
// array model: location data, program completion, page buffer handshake
`timescale 1ns/100ps
module frpc_array_model (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_arr_rd,
   input wire logic [frpc_pkg::LOC_W-1:0] i_arr_loc,
   output logic [63:0] o_arr_rdata,
   input wire logic i_arr_prog,
   output logic o_prog_done,
   input wire logic i_stall,
   output logic o_pbuf_ready
);
   logic [frpc_pkg::LOC_W-1:0] last_q;
   logic [1:0] hold_q;
   logic [3:0] prog_q;
   logic [31:0] cnt_q;
   function automatic logic [63:0] pat(input logic [frpc_pkg::LOC_W-1:0] loc);
      // page 3 reads as erased
      if (loc[frpc_pkg::LOC_W-1:5] == 16'h0003)
         return '1;
      return {11'h2a5, loc, 11'h35a, ~loc};
   endfunction
   // data stands for the fetch cycle and two more, then turns to noise
   always_comb
   begin
      if (i_arr_rd)
         o_arr_rdata = pat(i_arr_loc);
      else if (hold_q != 2'h0)
         o_arr_rdata = pat(last_q);
      else
         o_arr_rdata = ~pat(last_q) ^ {32'h0, cnt_q};
   end
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         last_q <= '0;
         hold_q <= 2'h0;
         prog_q <= 4'h0;
         cnt_q <= 32'h0;
         o_prog_done <= 1'b0;
         o_pbuf_ready <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_q + 32'h1;
         o_prog_done <= 1'b0;
         o_pbuf_ready <= !i_stall && $urandom_range(1, 0) == 1;
         if (i_arr_rd)
         begin
            last_q <= i_arr_loc;
            hold_q <= 2'h2;
         end
         else if (hold_q != 2'h0)
            hold_q <= hold_q - 2'h1;
         if (i_arr_prog)
            prog_q <= 4'($urandom_range(8, 3));
         else if (prog_q != 4'h0)
         begin
            prog_q <= prog_q - 4'h1;
            o_prog_done <= prog_q == 4'h1;
         end
      end
   end
endmodule // frpc_array_model

// ---- bench/flash_read_path_controller_test.sv ----
// testbench: reads, commands and page buffer writes against the array model
`timescale 1ns/100ps
module flash_read_path_controller_test;
   logic i_mclk, i_reset_n, i_wait_state_select, i_sequential_buffer_enable;
   logic i_branch_buffer_enable, i_status_clear, i_rd_req, o_rd_ready, o_rd_valid;
   logic [15:0] i_region_lock;
   logic [23:0] i_rd_addr, i_pbw_addr;
   logic [31:0] o_rd_data, i_pbw_data, o_pbuf_data;
   logic i_pbw_valid, o_pbw_ready, o_pbuf_wr, i_pbuf_ready, i_cmd_valid;
   logic [5:0] o_pbuf_idx;
   logic [3:0] i_cmd, o_arr_op, last_op;
   logic [9:0] i_cmd_page, o_arr_page, last_page;
   logic o_command_ready, o_fast_read_active, o_page_check_result, o_lock_error;
   logic o_arr_rd, o_arr_prog, i_arr_prog_done, stall;
   logic [20:0] o_arr_loc;
   logic [63:0] i_arr_rdata;
   logic [31:0] rd_q[$];
   logic [37:0] pb_q[$];
   int cyc = 0, t_last = 0, n_rd = 0, n_prog = 0, n_fail = 0, checked = 0;
   int k, n, r0;
   bit ok;
   frpc_top dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .i_wait_state_select(i_wait_state_select),
      .i_sequential_buffer_enable(i_sequential_buffer_enable),
      .i_branch_buffer_enable(i_branch_buffer_enable), .i_region_lock(i_region_lock),
      .i_status_clear(i_status_clear), .i_rd_req(i_rd_req), .i_rd_addr(i_rd_addr),
      .o_rd_ready(o_rd_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
      .i_pbw_valid(i_pbw_valid), .i_pbw_addr(i_pbw_addr), .i_pbw_data(i_pbw_data),
      .o_pbw_ready(o_pbw_ready), .o_pbuf_wr(o_pbuf_wr), .o_pbuf_idx(o_pbuf_idx),
      .o_pbuf_data(o_pbuf_data), .i_pbuf_ready(i_pbuf_ready), .i_cmd_valid(i_cmd_valid),
      .i_cmd(i_cmd), .i_cmd_page(i_cmd_page), .o_command_ready(o_command_ready),
      .o_fast_read_active(o_fast_read_active), .o_page_check_result(o_page_check_result),
      .o_lock_error(o_lock_error), .o_arr_rd(o_arr_rd), .o_arr_loc(o_arr_loc),
      .i_arr_rdata(i_arr_rdata), .o_arr_prog(o_arr_prog), .o_arr_op(o_arr_op),
      .o_arr_page(o_arr_page), .i_arr_prog_done(i_arr_prog_done));
   frpc_array_model model (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_arr_rd(o_arr_rd),
      .i_arr_loc(o_arr_loc), .o_arr_rdata(i_arr_rdata), .i_arr_prog(o_arr_prog),
      .o_prog_done(i_arr_prog_done), .i_stall(stall), .o_pbuf_ready(i_pbuf_ready));
   initial
   begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("counts: %0d checks, %0d mismatches", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   function automatic logic [31:0] rd_exp(input logic [23:0] a);
      logic [63:0] w;
      w = model.pat(a[23:3]);
      if (a < frpc_pkg::ARRAY_BYTES || (a >= frpc_pkg::USER_BASE && a < frpc_pkg::USER_END))
         return a[2] ? w[63:32] : w[31:0];
      return frpc_pkg::RESERVED_DATA;
   endfunction
   // span: edges from first take to the edge that sees the last answer
   task automatic burst(input logic [23:0] a, input int cnt, input int span);
      int t0;
      int j;
      t0 = -1;
      for (j = 0; j < cnt; j++)
      begin
         i_rd_req <= 1'b1;
         i_rd_addr <= a + 24'(4 * j);
         do
            @(posedge i_mclk);
         while (o_rd_ready !== 1'b1);
         if (t0 < 0)
            t0 = cyc;
         rd_q.push_back(rd_exp(a + 24'(4 * j)));
      end
      i_rd_req <= 1'b0;
      for (j = 0; j < 40 && rd_q.size() != 0; j++)
         @(posedge i_mclk);
      repeat (4) @(posedge i_mclk);
      chk(64'(t_last - t0), 64'(span));
   endtask
   task automatic cmd(input logic [3:0] code, input logic [9:0] page);
      int j;
      i_cmd_valid <= 1'b1;
      i_cmd <= code;
      i_cmd_page <= page;
      @(posedge i_mclk);
      i_cmd_valid <= 1'b0;
      @(posedge i_mclk);
      chk(64'(o_command_ready), 64'h0);
      for (j = 0; j < 400 && o_command_ready !== 1'b1; j++)
         @(posedge i_mclk);
      chk(64'(o_command_ready), 64'h1);
   endtask
   always @(posedge i_mclk)
      cyc <= cyc + 1;
   always @(posedge i_mclk)
   begin
      if (i_reset_n === 1'b1 && o_rd_valid === 1'b1)
      begin
         t_last = cyc;
         if (rd_q.size() == 0)
            chk(64'(o_rd_valid), 64'h0);
         else
            chk(64'(o_rd_data), 64'(rd_q.pop_front()));
      end
      if (o_pbuf_wr === 1'b1 && i_pbuf_ready === 1'b1)
      begin
         if (pb_q.size() == 0)
            chk(64'(o_pbuf_wr), 64'h0);
         else
            chk(64'({o_pbuf_idx, o_pbuf_data}), 64'(pb_q.pop_front()));
      end
      if (o_arr_rd === 1'b1)
         n_rd++;
      if (o_arr_prog === 1'b1)
      begin
         n_prog++;
         last_op = o_arr_op;
         last_page = o_arr_page;
      end
   end
   initial
   begin
      repeat (20000) @(posedge i_mclk);
      n_fail++;
      results();
   end
   initial
   begin
      void'($urandom(71558));
      {i_reset_n, i_wait_state_select, i_sequential_buffer_enable} = 3'h0;
      {i_branch_buffer_enable, i_status_clear, i_rd_req, i_pbw_valid, i_cmd_valid} = 5'h0;
      {i_region_lock, i_rd_addr, i_pbw_addr, i_pbw_data, i_cmd, i_cmd_page} = '0;
      stall = 1'b1;
      repeat (10) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      @(posedge i_mclk);
      chk(64'(o_fast_read_active), 64'h0);
      chk(64'({o_command_ready, o_rd_ready}), 64'h3);
      $display("test reset done");
      i_sequential_buffer_enable <= 1'b1;
      i_branch_buffer_enable <= 1'b1;
      @(posedge i_mclk);
      r0 = n_rd;
      burst(24'h000104, 8, 9);
      chk(64'(n_rd - r0), 64'h8);
      for (k = 0; k < 6; k++)
         burst(24'($urandom) & 24'h03fffc, 1, 2);
      burst(24'h8000f8, 1, 2);
      $display("test zero wait done");
      i_wait_state_select <= 1'b1;
      i_sequential_buffer_enable <= 1'b0;
      i_branch_buffer_enable <= 1'b0;
      @(posedge i_mclk);
      burst(24'h000200, 4, 6);
      burst(24'h000304, 4, 7);
      burst(24'h000400, 1, 3);
      burst(24'h000400, 1, 3);
      burst(24'h000404, 1, 2);
      burst(24'h800010, 1, 3);
      burst(24'h03fffc, 1, 3);
      burst(24'h400000, 1, 2);
      i_branch_buffer_enable <= 1'b1;
      burst(24'h000500, 1, 3);
      burst(24'h000500, 1, 2);
      i_sequential_buffer_enable <= 1'b1;
      burst(24'h000600, 4, 6);
      burst(24'h000700, 1, 3);
      burst(24'h000708, 1, 2);
      $display("test one wait done");
      i_sequential_buffer_enable <= 1'b0;
      i_branch_buffer_enable <= 1'b0;
      i_region_lock <= 16'h0004;
      repeat (4) @(posedge i_mclk);
      cmd(frpc_pkg::CMD_FAST_ON, 10'h000);
      chk(64'(o_fast_read_active), 64'h1);
      cmd(frpc_pkg::CMD_FAST_OFF, 10'h000);
      chk(64'(o_fast_read_active), 64'h0);
      r0 = n_rd;
      cmd(frpc_pkg::CMD_PAGE_CHECK, 10'h003);
      chk(64'(o_page_check_result), 64'h1);
      chk(64'(n_rd - r0), 64'h20);
      cmd(frpc_pkg::CMD_PAGE_CHECK, 10'h005);
      chk(64'(o_page_check_result), 64'h0);
      cmd(frpc_pkg::CMD_USER_CHECK, 10'h000);
      chk(64'(o_page_check_result), 64'h0);
      for (k = 1; k < 5; k++)
      begin
         r0 = n_prog;
         cmd(4'(k), 10'h005);
         chk(64'({n_prog - r0, last_op, last_page}), 64'({32'h1, 4'(k), 10'h005}));
      end
      r0 = n_prog;
      cmd(frpc_pkg::CMD_ERASE_PAGE, 10'h085);
      chk(64'({n_prog - r0, o_lock_error}), 64'h1);
      i_status_clear <= 1'b1;
      @(posedge i_mclk);
      i_status_clear <= 1'b0;
      repeat (2) @(posedge i_mclk);
      chk(64'(o_lock_error), 64'h0);
      $display("test commands done");
      n = 0;
      ok = 1'b1;
      for (k = 0; k < 8 && ok; k++)
      begin
         i_pbw_valid <= 1'b1;
         i_pbw_addr <= {16'h0, 6'(k), 2'h0};
         i_pbw_data <= $urandom;
         ok = 1'b0;
         for (r0 = 0; r0 < 6 && !ok; r0++)
         begin
            @(posedge i_mclk);
            ok = o_pbw_ready === 1'b1;
         end
         if (ok)
         begin
            pb_q.push_back({i_pbw_addr[7:2], i_pbw_data});
            n++;
         end
      end
      i_pbw_valid <= 1'b0;
      chk(64'(n >= frpc_pkg::FIFO_DEPTH && n < 8), 64'h1);
      stall <= 1'b0;
      for (k = 0; k < 80 && pb_q.size() != 0; k++)
         @(posedge i_mclk);
      chk(64'(pb_q.size()), 64'h0);
      $display("test page buffer done");
      results();
   end
endmodule // flash_read_path_controller_test
